/* scsc_pkg.sv */
// scsc_pkg: addresses, field positions, reset values and types of the
// serial channel with smart card option.
// assumes a byte-wide register port with 16-bit addresses.
package scsc_pkg;

  // register addresses
  localparam logic [15:0] ADDR_MODE     = 16'hff88;
  localparam logic [15:0] ADDR_BRATE    = 16'hff89;
  localparam logic [15:0] ADDR_CTRL     = 16'hff8a;
  localparam logic [15:0] ADDR_TXH      = 16'hff8b;
  localparam logic [15:0] ADDR_STAT     = 16'hff8c;
  localparam logic [15:0] ADDR_RXH      = 16'hff8d;
  localparam logic [15:0] ADDR_CARD     = 16'hff8e;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'hff70;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hff71;

  // field positions
  localparam int MODE_SYNC      = 7;  // 0 async, 1 clocked sync
  localparam int CTRL_TX_IE     = 7;  // tx empty request enable
  localparam int CTRL_RX_IE     = 6;  // stored only
  localparam int CTRL_TX_EN     = 5;  // transmit enable
  localparam int CTRL_RX_EN     = 4;  // receive enable
  localparam int STAT_TX_EMPTY  = 7;
  localparam int STAT_RX_FULL   = 6;
  localparam int STAT_OVERRUN   = 5;
  localparam int STAT_FRAME_ERR = 4;
  localparam int STAT_TX_END    = 2;
  localparam int CARD_MSB       = 3;  // bit order select
  localparam int IRQ_TXE        = 0;
  localparam int IRQ_RXF        = 1;
  localparam int IRQ_TEND       = 2;
  localparam int IRQ_ERR        = 3;

  // reset values and masks
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] BRATE_RST = 8'hff;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] TXH_RST   = 8'hff;
  localparam logic [7:0] RXH_RST   = 8'h00;
  localparam logic [7:0] CARD_RST  = 8'h00;
  localparam logic [7:0] STAT_RST  = 8'h84;
  localparam logic [7:0] STAT_MASK = 8'hf4;  // implemented flags
  localparam logic [7:0] IRQ_RST   = 8'h00;
  localparam logic [7:0] IRQ_MASK  = 8'h0f;

  // clock cycles per bit for each step of the rate register
  localparam int BIT_MULT_DEF = 16;

  // register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } scsc_bus_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } scsc_tx_st_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } scsc_rx_st_t;

  // reverse a byte when msb-first order is selected
  function automatic logic [7:0] bit_order(input logic [7:0] d, input logic msb);
    logic [7:0] r;
    r = d;
    if (msb) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7 - i];
      end
    end
    return r;
  endfunction : bit_order

endpackage : scsc_pkg

/* scsc_channel.sv */
// scsc_channel: one serial channel with smart card option, registers,
// transmitter, receiver and interrupt logic.
// assumes a synchronous register port and pins sampled on i_core_clk.
//
// Functional notes
// R01 - card order bit: lsb or msb first
// R02 - mode bit: 0 async, 1 clocked sync
// R03 - write 0 after reading 1 clears flag
// R04 - transfer controller write clears tx empty
// R05 - tx empty held 1 while tx disabled
// R06 - moving data to shifter sets tx empty
// R07 - flags take only a clearing 0
// R08 - tx interrupt enable gates empty requests
// R09 - timing counted in one-bit time units
// R10 - tx holding register keeps next character
// R11 - received character stored in rx holding
// R12 - request high while empty and enabled
// R13 - rx holding is read-only
`timescale 1ns/1ps
module scsc_channel import scsc_pkg::*; #(
  parameter int BIT_MULT = BIT_MULT_DEF
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire scsc_bus_t  i_bus,
  output logic      [7:0] o_rdata,
  input  wire logic       i_xfer_wr,
  input  wire logic [7:0] i_xfer_data,
  input  wire logic       i_rxd,
  output logic            o_txd,
  output logic            o_sck,
  output logic            o_sck_oe,
  output logic            o_tx_empty_irq,
  output logic            o_irq
);

  //////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] mode;      // serial_mode_reg
  logic [7:0] brate;     // bit rate step
  logic [7:0] ctrl;      // serial_control_reg
  logic [7:0] txh;       // tx_holding_reg
  logic [7:0] stat;      // serial_status_reg
  logic [7:0] rxh;       // rx_holding_reg
  logic [7:0] card;      // card_mode_reg
  logic [7:0] seen;      // flags last read as one
  logic [7:0] irq_stat;  // sticky events
  logic [7:0] irq_mask;  // event mask
  logic [7:0] next_mode, next_brate, next_ctrl, next_txh, next_stat;
  logic [7:0] next_rxh, next_card, next_seen, next_irq_stat, next_irq_mask;
  logic [7:0] next_rdata;
  logic [7:0] sw_clr;    // flags cleared by software
  logic [7:0] w1c;       // event bits written with one

  // transmitter state
  scsc_tx_st_t tx_state, next_tx_state;
  logic [7:0]  tx_shift, next_tx_shift;  // tx_shift_register
  logic [2:0]  tx_bit, next_tx_bit;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic        next_txd, next_sck;
  logic        load_ev;                  // holding moved to shifter
  logic        tend_ev;                  // frame ended with nothing queued

  // receiver state
  scsc_rx_st_t rx_state, next_rx_state;
  logic [7:0]  rx_shift, next_rx_shift;
  logic [2:0]  rx_bit, next_rx_bit;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic        rx_done;                  // character complete
  logic        rx_ferr;                  // stop bit was low
  logic [7:0]  rx_word;                  // shifter with current bit
  logic [7:0]  rx_byte;                  // character to store

  //////////////////////////////////////////////////////////////////////////
  // decoded control
  logic        sync_mode, transmit_enable_bit, rx_en, card_msb;
  logic        tx_empty_flag, rx_full;
  logic [15:0] bit_len, half_len;
  logic        tx_tick, rx_tick, sync_sample;

  assign sync_mode           = mode[MODE_SYNC];        // R02
  assign transmit_enable_bit = ctrl[CTRL_TX_EN];
  assign rx_en               = ctrl[CTRL_RX_EN];
  assign card_msb            = card[CARD_MSB];
  assign tx_empty_flag       = stat[STAT_TX_EMPTY];
  assign rx_full             = stat[STAT_RX_FULL];

  // one etu in clock cycles, shared by both directions
  assign bit_len  = 16'((32'(brate) + 32'd1) * BIT_MULT);  // R09
  assign half_len = bit_len >> 1;
  assign tx_tick  = (tx_cnt == bit_len - 16'h0001);
  assign rx_tick  = (rx_cnt == bit_len - 16'h0001);
  // sync receive samples where the clock output rises
  assign sync_sample = sync_mode && rx_en && (tx_state == TX_DATA)
                       && (tx_cnt == half_len - 16'h0001);

  //////////////////////////////////////////////////////////////////////////
  // register file: writes, flag rules, reads
  always_comb begin
    next_mode     = mode;
    next_brate    = brate;
    next_ctrl     = ctrl;
    next_txh      = txh;
    next_rxh      = rxh;
    next_card     = card;
    next_seen     = (i_bus.wr && i_bus.addr == ADDR_STAT) ? 8'h00 : (seen & stat);  // R03
    next_irq_mask = irq_mask;
    next_rdata    = 8'h00;
    w1c           = 8'h00;
    if (i_bus.wr) begin
      case (i_bus.addr)
        ADDR_MODE:     next_mode     = i_bus.wdata;
        ADDR_BRATE:    next_brate    = i_bus.wdata;
        ADDR_CTRL:     next_ctrl     = i_bus.wdata;
        ADDR_TXH:      next_txh      = i_bus.wdata;  // R10
        ADDR_CARD:     next_card     = i_bus.wdata;
        ADDR_IRQ_MASK: next_irq_mask = i_bus.wdata & IRQ_MASK;
        ADDR_IRQ_STAT: w1c           = i_bus.wdata & IRQ_MASK;
        default: ;  // status via sw_clr; rx holding ignores writes R13
      endcase
    end
    // zero written over a flag previously read as one
    sw_clr = (i_bus.wr && i_bus.addr == ADDR_STAT) ? (~i_bus.wdata & seen) : 8'h00; // R03 R07
    // controller write lands in holding register
    if (i_xfer_wr) begin
      next_txh = i_xfer_data;  // R10
    end
    // flags: a set wins over a clear in the same cycle
    next_stat = stat & STAT_MASK;
    next_stat[STAT_TX_EMPTY] = (tx_empty_flag && !sw_clr[STAT_TX_EMPTY] && !i_xfer_wr) // R03 R04
                               || load_ev || !transmit_enable_bit;  // R05 R06
    next_stat[STAT_TX_END]   = (stat[STAT_TX_END] && !sw_clr[STAT_TX_END] && !i_xfer_wr)
                               || tend_ev || !transmit_enable_bit;
    next_stat[STAT_RX_FULL]  = (rx_full && !sw_clr[STAT_RX_FULL]) || rx_done;  // R11
    next_stat[STAT_OVERRUN]  = (stat[STAT_OVERRUN] && !sw_clr[STAT_OVERRUN])
                               || (rx_done && rx_full);
    next_stat[STAT_FRAME_ERR] = (stat[STAT_FRAME_ERR] && !sw_clr[STAT_FRAME_ERR])
                                || (rx_done && rx_ferr);
    // store character unless the previous one is still unread
    if (rx_done && !rx_full) begin
      next_rxh = bit_order(rx_byte, card_msb);  // R01 R11
    end
    // sticky events, set wins over write-one clear
    next_irq_stat = irq_stat & ~w1c;
    next_irq_stat[IRQ_TXE]  = next_irq_stat[IRQ_TXE] | load_ev;
    next_irq_stat[IRQ_RXF]  = next_irq_stat[IRQ_RXF] | rx_done;
    next_irq_stat[IRQ_TEND] = next_irq_stat[IRQ_TEND] | tend_ev;
    next_irq_stat[IRQ_ERR]  = next_irq_stat[IRQ_ERR] | (rx_done & (rx_ferr | rx_full));
    // read data, one cycle later; status read arms clearing
    if (i_bus.rd) begin
      case (i_bus.addr)
        ADDR_MODE:     next_rdata = mode;
        ADDR_BRATE:    next_rdata = brate;
        ADDR_CTRL:     next_rdata = ctrl;
        ADDR_TXH:      next_rdata = txh;
        ADDR_STAT: begin
          next_rdata = stat & STAT_MASK;
          next_seen  = stat & STAT_MASK;  // R03
        end
        ADDR_RXH:      next_rdata = rxh;
        ADDR_CARD:     next_rdata = card;
        ADDR_IRQ_STAT: next_rdata = irq_stat;
        ADDR_IRQ_MASK: next_rdata = irq_mask;
        default:       next_rdata = 8'h00;
      endcase
    end
  end

  // register file flip-flops
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      mode     <= MODE_RST;
      brate    <= BRATE_RST;
      ctrl     <= CTRL_RST;
      txh      <= TXH_RST;
      stat     <= STAT_RST;
      rxh      <= RXH_RST;
      card     <= CARD_RST;
      seen     <= 8'h00;
      irq_stat <= IRQ_RST;
      irq_mask <= IRQ_RST;
      o_rdata  <= 8'h00;
    end else begin
      mode     <= next_mode;
      brate    <= next_brate;
      ctrl     <= next_ctrl;
      txh      <= next_txh;
      stat     <= next_stat;
      rxh      <= next_rxh;
      card     <= next_card;
      seen     <= next_seen;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      o_rdata  <= next_rdata;
    end
  end

  // request lines
  assign o_tx_empty_irq = tx_empty_flag && ctrl[CTRL_TX_IE];  // R08 R12
  assign o_irq          = |(irq_stat & irq_mask);
  assign o_sck_oe       = sync_mode;

  //////////////////////////////////////////////////////////////////////////
  // transmitter: start, eight data bits, stop (no start/stop in sync)
  always_comb begin
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_bit   = tx_bit;
    next_tx_cnt   = tx_tick ? 16'h0000 : tx_cnt + 16'h0001;  // R09
    load_ev       = 1'b0;
    tend_ev       = 1'b0;
    case (tx_state)
      TX_IDLE: begin
        next_tx_cnt = 16'h0000;
        // holding register full: move it to the shifter
        if (transmit_enable_bit && !tx_empty_flag) begin
          load_ev       = 1'b1;  // R06
          next_tx_shift = bit_order(txh, card_msb);  // R01
          next_tx_bit   = 3'd0;
          next_tx_state = sync_mode ? TX_DATA : TX_START;  // R02
        end
      end
      TX_START: begin
        if (tx_tick) begin
          next_tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_tick) begin
          next_tx_shift = {1'b1, tx_shift[7:1]};
          next_tx_bit   = tx_bit + 3'd1;
          if (tx_bit == 3'd7) begin
            // sync frames have no stop bit
            next_tx_state = sync_mode ? TX_IDLE : TX_STOP;  // R02
            tend_ev       = sync_mode && tx_empty_flag;
          end
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          next_tx_state = TX_IDLE;
          tend_ev       = tx_empty_flag;
        end
      end
      default: next_tx_state = TX_IDLE;
    endcase
    // disabling the transmitter abandons the frame
    if (!transmit_enable_bit) begin
      next_tx_state = TX_IDLE;
      load_ev       = 1'b0;
      tend_ev       = 1'b0;
    end
    // line level follows the next state
    case (next_tx_state)
      TX_START: next_txd = 1'b0;
      TX_DATA:  next_txd = next_tx_shift[0];
      default:  next_txd = 1'b1;
    endcase
    // clock low in the first half of each sync bit
    next_sck = !(sync_mode && next_tx_state == TX_DATA && next_tx_cnt < half_len);
  end

  // transmitter flip-flops
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_state <= TX_IDLE;
      tx_shift <= 8'hff;
      tx_bit   <= 3'd0;
      tx_cnt   <= 16'h0000;
      o_txd    <= 1'b1;
      o_sck    <= 1'b1;
    end else begin
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_bit   <= next_tx_bit;
      tx_cnt   <= next_tx_cnt;
      o_txd    <= next_txd;
      o_sck    <= next_sck;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receiver: async samples mid-bit, sync samples on clock rise
  always_comb begin
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_bit   = rx_bit;
    next_rx_cnt   = rx_cnt + 16'h0001;
    rx_done       = 1'b0;
    rx_ferr       = 1'b0;
    rx_word       = {i_rxd, rx_shift[7:1]};
    rx_byte       = rx_shift;
    case (rx_state)
      RX_IDLE: begin
        next_rx_cnt = 16'h0000;
        if (sync_mode) begin
          // bits arrive alongside our own clocked frame
          if (sync_sample) begin
            next_rx_shift = rx_word;
            next_rx_bit   = rx_bit + 3'd1;
            if (rx_bit == 3'd7) begin
              rx_done = 1'b1;  // R11
              rx_byte = rx_word;
            end
          end
        end else begin
          next_rx_bit = 3'd0;
          if (rx_en && !i_rxd) begin
            next_rx_state = RX_START;
          end
        end
      end
      RX_START: begin
        // recheck start bit at its middle, filters glitches
        if (rx_cnt == half_len - 16'h0001) begin
          next_rx_cnt   = 16'h0000;
          next_rx_state = i_rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          next_rx_cnt   = 16'h0000;
          next_rx_shift = rx_word;
          next_rx_bit   = rx_bit + 3'd1;
          if (rx_bit == 3'd7) begin
            next_rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          rx_done       = 1'b1;  // R11
          rx_ferr       = !i_rxd;
          next_rx_state = RX_IDLE;
        end
      end
      default: next_rx_state = RX_IDLE;
    endcase
    // receiver off: drop any partial character
    if (!rx_en) begin
      next_rx_state = RX_IDLE;
      next_rx_bit   = 3'd0;
      rx_done       = 1'b0;
      rx_ferr       = 1'b0;
    end
  end

  // receiver flip-flops
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_state <= RX_IDLE;
      rx_shift <= 8'h00;
      rx_bit   <= 3'd0;
      rx_cnt   <= 16'h0000;
    end else begin
      rx_state <= next_rx_state;
      rx_shift <= next_rx_shift;
      rx_bit   <= next_rx_bit;
      rx_cnt   <= next_rx_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking chk_cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  logic wr_stat;
  assign wr_stat = i_bus.wr && (i_bus.addr == ADDR_STAT);

  chk_order_load: assert property ( // R01
    load_ev |=> tx_shift == bit_order($past(txh), $past(card_msb)))
    else $error("shifter not loaded in selected bit order");
  chk_async_start: assert property ( // R02
    load_ev && !sync_mode |=> !o_txd ##1 !o_txd)
    else $error("async frame did not begin with a low start bit");
  chk_unarmed_write: assert property ( // R03
    wr_stat && !seen[STAT_TX_EMPTY] && tx_empty_flag && !i_xfer_wr
    |=> tx_empty_flag)
    else $error("tx empty cleared without a prior read");
  chk_xfer_clear: assert property ( // R04
    i_xfer_wr && transmit_enable_bit && tx_state != TX_IDLE
    && $past(transmit_enable_bit) |=> !tx_empty_flag)
    else $error("controller write did not clear tx empty");
  chk_disabled_empty: assert property ( // R05
    !transmit_enable_bit |=> tx_empty_flag && tx_state == TX_IDLE)
    else $error("tx empty not held while transmitter off");
  chk_load_sets: assert property ( // R06
    load_ev |=> tx_empty_flag && tx_state != TX_IDLE)
    else $error("move to shifter did not set tx empty");
  chk_write_one: assert property ( // R07
    wr_stat && i_bus.wdata[STAT_RX_FULL] && rx_full |=> rx_full)
    else $error("writing one changed a flag");
  chk_irq_gate: assert property ( // R08
    !ctrl[CTRL_TX_IE] |-> !o_tx_empty_irq)
    else $error("request raised while disabled");
  chk_etu_bound: assert property ( // R09
    tx_state == TX_START && tx_tick && transmit_enable_bit
    |=> tx_state == TX_DATA && tx_cnt == 16'h0000)
    else $error("start bit length differs from one etu");
  chk_hold_stable: assert property ( // R10
    !i_xfer_wr && !(i_bus.wr && i_bus.addr == ADDR_TXH) |=> $stable(txh))
    else $error("tx holding changed without a write");
  chk_rx_store: assert property ( // R11
    rx_done && !rx_full |=> rx_full ##0 rxh == bit_order($past(rx_byte), $past(card_msb)))
    else $error("received character not stored");
  chk_irq_follow: assert property ( // R12
    tx_empty_flag && ctrl[CTRL_TX_IE] |-> o_tx_empty_irq)
    else $error("request missing while empty and enabled");
  chk_rxh_readonly: assert property ( // R13
    i_bus.wr && i_bus.addr == ADDR_RXH && !rx_done |=> $stable(rxh))
    else $error("write reached rx holding register");

  cov_load: cover property (load_ev);
  cov_rx_done: cover property (rx_done && !rx_full);
  cov_tx_end: cover property (tend_ev);
  cov_overrun: cover property (rx_done && rx_full);

endmodule : scsc_channel

/* scsc_peer.sv */
// scsc_peer: far-side serial partner of the channel, async 8-bit frames.
// assumes the channel is set so that one bit lasts ETU core clocks.
`timescale 1ns/1ps
module scsc_peer #(
  parameter int ETU = 4
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_txd,
  output logic            o_rxd,
  output logic [7:0]      o_seen,
  output logic [7:0]      o_frames
);
  logic [7:0] shift_q;  // bits as they came, first on the wire in bit 0

  initial begin
    o_rxd    = 1'b1;
    o_seen   = 8'h00;
    o_frames = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive side: looks on falling edges, clear of the channel's launches
  always begin
    @(negedge i_core_clk);
    if (i_txd === 1'b0) begin
      repeat (ETU / 2) @(negedge i_core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (ETU) @(negedge i_core_clk);
        shift_q[i] = i_txd;
      end
      repeat (ETU) @(negedge i_core_clk);
      o_seen   = shift_q;
      o_frames = o_frames + 8'h01;
      while (i_txd !== 1'b1) @(negedge i_core_clk);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // send side: start bit, data lsb first, stop bit, line back idle high
  task automatic send(input logic [7:0] d);
    @(posedge i_core_clk);
    o_rxd <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      repeat (ETU) @(posedge i_core_clk);
      o_rxd <= d[i];
    end
    repeat (ETU) @(posedge i_core_clk);
    o_rxd <= 1'b1;
    repeat (ETU) @(posedge i_core_clk);
  endtask : send
endmodule : scsc_peer

/* scsc_channel_tb.sv */
// scsc_channel_tb: self-checking bench for the serial channel.
// assumes BIT_MULT 2 and rate 1, so one bit lasts 4 core clocks.
`timescale 1ns/1ps
module scsc_channel_tb import scsc_pkg::*;;
  logic       i_core_clk = 1'b0;
  logic       i_reset    = 1'b1;
  scsc_bus_t  bus        = '0;     // register port request
  logic       xfer_wr    = 1'b0;   // transfer controller strobe
  logic [7:0] xfer_data  = 8'h00;
  logic [7:0] rdata;
  logic       rxd, txd, sck, sck_oe, txe_irq, irq;
  logic [7:0] seen, frames;       // partner's last byte and frame count
  int         fail_count = 0;
  int         tests_run  = 0;

  always #20 i_core_clk = ~i_core_clk;

  scsc_channel #(.BIT_MULT(2)) dut_u (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata),
    .i_xfer_wr(xfer_wr), .i_xfer_data(xfer_data), .i_rxd(rxd), .o_txd(txd),
    .o_sck(sck), .o_sck_oe(sck_oe), .o_tx_empty_irq(txe_irq), .o_irq(irq));
  scsc_peer #(.ETU(4)) peer_u (
    .i_core_clk(i_core_clk), .i_txd(txd), .o_rxd(rxd), .o_seen(seen),
    .o_frames(frames));

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  function automatic logic [7:0] flip(input logic [7:0] d);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = d[7 - i];
    return r;
  endfunction : flip

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic do_reset();
    i_reset <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_reset <= 1'b0;
  endtask : do_reset

  // one-cycle write, ends mid-cycle so outputs have settled
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_core_clk);
    bus <= '0;
    @(negedge i_core_clk);
  endtask : wr

  // one-cycle read, data taken in the following cycle only
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_core_clk);
    bus <= '0;
    @(negedge i_core_clk);
    d = rdata;
  endtask : rd

  task automatic xfer(input logic [7:0] d);
    @(posedge i_core_clk);
    xfer_wr   <= 1'b1;
    xfer_data <= d;
    @(posedge i_core_clk);
    xfer_wr   <= 1'b0;
    @(negedge i_core_clk);
  endtask : xfer

  // bounded wait for the partner to finish a frame
  task automatic wait_frames(input logic [7:0] n);
    for (int k = 0; k < 400 && frames !== n; k++) @(posedge i_core_clk);
    if (frames !== n) begin
      chk("frame count", n, frames);
      report_and_stop();
    end
  endtask : wait_frames

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [15:0] a [10] = '{ADDR_MODE, ADDR_BRATE, ADDR_CTRL, ADDR_TXH, ADDR_STAT,
                            ADDR_RXH, ADDR_CARD, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 16'hff87};
    logic [7:0]  e [10] = '{MODE_RST, BRATE_RST, CTRL_RST, TXH_RST, STAT_RST,
                            RXH_RST, CARD_RST, IRQ_RST, IRQ_RST, 8'h00};
    logic [7:0]  d;
    for (int i = 0; i < 10; i++) begin
      rd(a[i], d);
      chk("reset value", e[i], d);
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_flags();
    logic [7:0] d;
    logic [7:0] base;
    @(posedge i_core_clk);
    do_reset();
    base = frames;
    wr(ADDR_BRATE, 8'h01);
    wr(ADDR_CTRL, 8'hb0);
    chk("irq on empty", 8'h01, {7'h00, txe_irq});
    wr(ADDR_TXH, 8'h5a);
    wr(ADDR_STAT, 8'h00);
    rd(ADDR_STAT, d);
    chk("unarmed clear", 8'h01, {7'h00, d[STAT_TX_EMPTY]});
    wr(ADDR_STAT, 8'hff);
    rd(ADDR_STAT, d);
    chk("written one", 8'h01, {7'h00, d[STAT_TX_EMPTY]});
    wr(ADDR_STAT, 8'h7f);
    wr(ADDR_TXH, 8'hc3);
    rd(ADDR_STAT, d);
    chk("set on load", 8'h01, {7'h00, d[STAT_TX_EMPTY]});
    wr(ADDR_STAT, 8'h7f);
    rd(ADDR_STAT, d);
    chk("armed clear", 8'h00, {7'h00, d[STAT_TX_EMPTY]});
    chk("irq removed", 8'h00, {7'h00, txe_irq});
    wait_frames(base + 8'h01);
    chk("first byte", 8'h5a, seen);
    wait_frames(base + 8'h02);
    chk("second byte", 8'hc3, seen);
    rd(ADDR_STAT, d);
    wr(ADDR_STAT, 8'h7f);
    wr(ADDR_STAT, 8'h7f);
    rd(ADDR_STAT, d);
    chk("stale arm", 8'h01, {7'h00, d[STAT_TX_EMPTY]});
    wait_frames(base + 8'h03);
    chk("third byte", 8'hc3, seen);
    wr(ADDR_CTRL, 8'h30);
    chk("irq gated", 8'h00, {7'h00, txe_irq});
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_STAT, d);
    wr(ADDR_STAT, 8'h7f);
    rd(ADDR_STAT, d);
    chk("held while off", 8'h01, {7'h00, d[STAT_TX_EMPTY]});
    $display("test flags done");
  endtask : t_flags

  task automatic t_order();
    logic [7:0] base;
    for (int m = 0; m < 2; m++) begin
      base = frames;
      wr(ADDR_CTRL, 8'h20);
      wr(ADDR_CARD, m[0] ? 8'h08 : 8'h00);
      xfer(8'h35);
      wait_frames(base + 8'h01);
      chk("tx order", m[0] ? flip(8'h35) : 8'h35, seen);
    end
    $display("test order done");
  endtask : t_order

  task automatic t_rx();
    logic [7:0] d;
    wr(ADDR_CTRL, 8'h10);
    wr(ADDR_IRQ_MASK, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CARD, m[0] ? 8'h08 : 8'h00);
      peer_u.send(8'hc6);
      d = 8'h00;
      for (int k = 0; k < 50 && d[STAT_RX_FULL] !== 1'b1; k++) rd(ADDR_STAT, d);
      chk("rx full", 8'h01, {7'h00, d[STAT_RX_FULL]});
      wr(ADDR_RXH, 8'h00);
      rd(ADDR_RXH, d);
      chk("rx data", m[0] ? flip(8'hc6) : 8'hc6, d);
      wr(ADDR_STAT, 8'hbf);
    end
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(ADDR_IRQ_MASK, 8'h02);
    chk("irq raised", 8'h01, {7'h00, irq});
    wr(ADDR_IRQ_STAT, 8'h02);
    chk("irq cleared", 8'h00, {7'h00, irq});
    $display("test rx done");
  endtask : t_rx

  task automatic t_sync();
    int         falls;
    logic       last;
    logic [7:0] got;
    logic [7:0] d;
    wr(ADDR_CTRL, 8'h30);
    wr(ADDR_MODE, 8'h80);
    chk("sck enable", 8'h01, {7'h00, sck_oe});
    xfer(8'h96);
    falls = 0;
    got   = 8'h00;
    last  = sck;
    repeat (80) begin
      @(negedge i_core_clk);
      if (last === 1'b1 && sck === 1'b0) falls++;
      // line value taken where the clock output rises
      if (last === 1'b0 && sck === 1'b1) got = {txd, got[7:1]};
      last = sck;
    end
    chk("sck pulses", 8'h08, falls[7:0]);
    chk("sync tx data", flip(8'h96), got);
    rd(ADDR_RXH, d);
    chk("sync rx data", 8'hff, d);
    wr(ADDR_MODE, 8'h00);
    chk("sck disable", 8'h00, {7'h00, sck_oe});
    $display("test sync done");
  endtask : t_sync

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    do_reset();
    t_reset();
    t_flags();
    t_order();
    t_rx();
    t_sync();
    report_and_stop();
  end
endmodule : scsc_channel_tb
